// *** hpp_pkg.sv ***
// Shared constants for the host parallel port block
package hpp_pkg;
    // Avalon register byte offsets
    localparam logic [4:0] HPP_OFF_CTRL = 5'h00;
    localparam logic [4:0] HPP_OFF_STATUS = 5'h04;
    localparam logic [4:0] HPP_OFF_RX_DATA = 5'h08;
    localparam logic [4:0] HPP_OFF_TX_DATA = 5'h0C;
    localparam logic [4:0] HPP_OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] HPP_OFF_IRQ_MASK = 5'h14;
    localparam logic [4:0] HPP_OFF_VECTOR = 5'h18;
    // Control register field positions
    localparam int HPP_CTRL_DUAL_STROBE = 0;
    localparam int HPP_CTRL_DOUBLE_REQ = 1;
    localparam int HPP_CTRL_MUX = 2;
    localparam int HPP_CTRL_OPEN_DRAIN = 3;
    localparam int HPP_CTRL_STROBE_POL = 4;
    localparam int HPP_CTRL_SELECT_POL = 5;
    localparam int HPP_CTRL_REQ_POL = 6;
    localparam int HPP_CTRL_ACK_POL = 7;
    localparam int HPP_CTRL_ALS_POL = 8;
    localparam int HPP_CTRL_W = 9;
    localparam logic [8:0] HPP_CTRL_RESET = 9'h001;
    // Interrupt event positions
    localparam int HPP_EV_TX_WRITTEN = 0;
    localparam int HPP_EV_RX_TAKEN = 1;
    localparam int HPP_EV_ICR_WRITTEN = 2;
    localparam int HPP_EV_W = 3;
    // Host window register indices
    localparam logic [2:0] HPP_HA_ICR = 3'h0;
    localparam logic [2:0] HPP_HA_STATUS = 3'h2;
    localparam logic [2:0] HPP_HA_VECTOR = 3'h3;
    localparam logic [2:0] HPP_HA_FIRST = 3'h5;
    localparam logic [2:0] HPP_HA_MID = 3'h6;
    localparam logic [2:0] HPP_HA_LAST = 3'h7;
    // Interface control register fields
    localparam int HPP_ICR_RX_REQ_EN = 0;
    localparam int HPP_ICR_TX_REQ_EN = 1;
    localparam int HPP_ICR_BYTE_ORDER = 7;
    localparam logic [7:0] HPP_ICR_RESET = 8'h00;
    // Settling time after an interface control write
    localparam int HPP_ICR_SETTLE_CYC = 3;
    localparam logic [1:0] HPP_SETTLE_LOAD = 2'(HPP_ICR_SETTLE_CYC);
    // Reset values
    localparam logic [7:0] HPP_VECTOR_RESET = 8'h0F;
    localparam logic [23:0] HPP_WORD_RESET = 24'h00_0000;
endpackage : hpp_pkg

// *** hpp_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous host pins
`timescale 1ns/100ps
module hpp_sync #(
    parameter int WIDTH = 8
) (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
    logic [WIDTH-1:0] sync_reg; // Second stage

    // Plain register chain; no logic between stages
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (i_clk_en) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule : hpp_sync

// *** hpp_req_drv.sv ***
// Host request pin driver with polarity and open-drain choice
`timescale 1ns/100ps
module hpp_req_drv (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Control
    input wire logic i_assert,
    input wire logic i_active_high,
    input wire logic i_open_drain,
    // Pin
    output logic o_pin_out,
    output logic o_pin_oe
);
    logic out_reg; // Pin level
    logic out_next;
    logic oe_reg; // Pin drive enable
    logic oe_next;

    // Open drain only ever pulls low; the pull-up gives the idle level
    always_comb begin
        if (i_open_drain) begin
            out_next = 1'b0;
            oe_next = i_assert;
        end else begin
            out_next = i_active_high ? i_assert : ~i_assert;
            oe_next = 1'b1;
        end
    end

    // Registered so the pin never glitches
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else if (i_clk_en) begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign o_pin_out = out_reg;
    assign o_pin_oe = oe_reg;
endmodule : hpp_req_drv

// *** hpp_host_port.sv ***
// Host parallel port: host pin handshake plus Avalon register slave
`timescale 1ns/100ps
module hpp_host_port
    import hpp_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Avalon-MM slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    // Host strobes and controls
    input wire logic i_port_select,
    input wire logic i_host_read_strobe,
    input wire logic i_host_write_strobe,
    input wire logic i_shared_data_strobe,
    input wire logic i_transfer_direction,
    input wire logic i_address_latch_strobe,
    input wire logic i_vector_acknowledge,
    // Host address and data
    input wire logic [2:0] i_host_address_inputs,
    input wire logic [2:0] i_host_high_address,
    input wire logic [7:0] i_shared_addr_data_lines,
    output logic [7:0] o_shared_addr_data_lines,
    output logic o_shared_addr_data_lines_oe,
    // Host requests
    output logic o_combined_host_request,
    output logic o_combined_host_request_oe,
    output logic o_receive_host_request,
    output logic o_receive_host_request_oe,
    output logic o_transmit_host_request,
    output logic o_transmit_host_request_oe
);
    // Byte of a 24-bit word at a host window index
    function automatic logic [7:0] hpp_pick(input logic [23:0] w, input logic [2:0] a,
                                             input logic little);
        logic [7:0] b;
        b = 8'h00;
        if (a == HPP_HA_MID) begin
            b = w[15:8];
        end else if (a == HPP_HA_FIRST) begin
            b = little ? w[7:0] : w[23:16];
        end else if (a == HPP_HA_LAST) begin
            b = little ? w[23:16] : w[7:0];
        end
        return b;
    endfunction : hpp_pick

    // Pin synchronisers
    logic [8:0] ctl_sync; // Synchronised control pins
    logic [13:0] bus_sync; // Synchronised address and data pins
    hpp_sync #(.WIDTH(9)) u_ctl_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        // Inverted in, so a cleared sync reads as idle pins after reset
        .i_async(~{i_port_select, i_host_read_strobe, i_host_write_strobe,
                  i_shared_data_strobe, i_transfer_direction, i_address_latch_strobe,
                  i_vector_acknowledge, 2'b00}),
        .o_sync(ctl_sync)
    );
    hpp_sync #(.WIDTH(14)) u_bus_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_async({i_host_address_inputs, i_host_high_address, i_shared_addr_data_lines}),
        .o_sync(bus_sync)
    );

    // Control register and configuration decode
    logic [HPP_CTRL_W-1:0] ctrl_reg; // Port mode and polarity
    logic [HPP_CTRL_W-1:0] ctrl_next;
    logic spol; // Strobes active high
    logic sel_act; // Select asserted
    logic rd_pin; // Read strobe asserted
    logic wr_pin; // Write strobe asserted
    logic ds_pin; // Shared strobe asserted
    logic als_act; // Address latch strobe asserted
    logic ack_act; // Vector acknowledge asserted
    logic rd_act; // Qualified read access
    logic wr_act; // Qualified write access
    always_comb begin
        spol = ctrl_reg[HPP_CTRL_STROBE_POL];
        sel_act = ctl_sync[8] ^ ctrl_reg[HPP_CTRL_SELECT_POL];
        rd_pin = ctl_sync[7] ^ spol;
        wr_pin = ctl_sync[6] ^ spol;
        ds_pin = ctl_sync[5] ^ spol;
        als_act = ctl_sync[3] ^ ctrl_reg[HPP_CTRL_ALS_POL];
        ack_act = ctl_sync[2] ^ ctrl_reg[HPP_CTRL_ACK_POL];
        if (ctrl_reg[HPP_CTRL_DUAL_STROBE]) begin
            rd_act = sel_act & rd_pin;
            wr_act = sel_act & wr_pin;
        end else begin
            rd_act = sel_act & ds_pin & ~ctl_sync[4];
            wr_act = sel_act & ds_pin & ctl_sync[4];
        end
    end

    // Host side state
    logic rd_d_reg, rd_d_next; // Read access seen last cycle
    logic wr_d_reg, wr_d_next; // Write access seen last cycle
    logic als_d_reg, als_d_next; // Latch strobe seen last cycle
    logic [7:0] alat_reg, alat_next; // Latched multiplexed address
    logic [2:0] acc_reg, acc_next; // Address held for the access
    logic [7:0] wdat_reg, wdat_next; // Data sampled during write
    logic [7:0] icr_reg, icr_next; // Interface control register
    logic [1:0] settle_reg, settle_next; // Cycles until ready again
    logic [23:0] rxw_reg, rxw_next; // Word toward the host
    logic [23:0] txw_reg, txw_next; // Word from the host
    logic rx_full_reg, rx_full_next; // Receive word waiting
    logic tx_full_reg, tx_full_next; // Transmit word waiting
    logic [7:0] vec_reg, vec_next; // Vector number
    logic [7:0] dout_reg, dout_next; // Host data out
    logic doe_reg, doe_next; // Host data drive enable
    logic [2:0] ev_set; // Events this cycle
    logic [2:0] cur_addr; // Register selected now
    logic addr_ok; // Access hits the window
    logic rd_rise, wr_rise, wr_fall; // Strobe edges
    logic last_rd, last_wr; // Last-register access in progress
    logic little; // Byte order select
    // Avalon side strobes feeding host state
    logic bus_req, bus_take; // Request present, request answered
    logic rx_load, tx_take; // Software loads rx, reads tx
    always_comb begin
        rd_rise = rd_act & ~rd_d_reg;
        wr_rise = wr_act & ~wr_d_reg;
        wr_fall = ~wr_act & wr_d_reg;
        little = icr_reg[HPP_ICR_BYTE_ORDER];
        // Mux mode uses the latched address, else the address held across the strobe by the host
        cur_addr = ctrl_reg[HPP_CTRL_MUX] ? alat_reg[2:0] : bus_sync[13:11];
        addr_ok = ctrl_reg[HPP_CTRL_MUX] ? (alat_reg[7:3] == 5'h00) : 1'b1;
        last_rd = rd_act & addr_ok & (cur_addr == HPP_HA_LAST);
        last_wr = wr_act & addr_ok & (acc_reg == HPP_HA_LAST);
        rd_d_next = rd_act;
        wr_d_next = wr_act;
        als_d_next = als_act;
        alat_next = alat_reg;
        acc_next = acc_reg;
        wdat_next = wdat_reg;
        icr_next = icr_reg;
        settle_next = (settle_reg != 2'd0) ? settle_reg - 2'd1 : settle_reg;
        rxw_next = rxw_reg;
        txw_next = txw_reg;
        rx_full_next = rx_full_reg;
        tx_full_next = tx_full_reg;
        vec_next = vec_reg;
        ev_set = 3'b000;
        // Low address taken as the latch strobe ends
        if (~als_act & als_d_reg) begin
            alat_next = bus_sync[7:0];
        end
        if (wr_rise) begin
            acc_next = cur_addr;
        end
        if (wr_act) begin
            wdat_next = bus_sync[7:0];
        end
        // Host access effects on flags and registers ignored while the port settles; read data is still driven
        if (settle_reg == 2'd0 && addr_ok) begin
            // Host read of the last byte frees the word
            if (rd_rise && cur_addr == HPP_HA_LAST && rx_full_reg) begin
                rx_full_next = 1'b0;
                ev_set[HPP_EV_RX_TAKEN] = 1'b1;
            end
            if (wr_rise && cur_addr == HPP_HA_LAST) begin
                tx_full_next = 1'b1;
            end
            // Write data committed as the strobe ends
            if (wr_fall) begin
                unique case (acc_reg)
                    HPP_HA_ICR: begin
                        icr_next = wdat_reg;
                        settle_next = HPP_SETTLE_LOAD;
                        ev_set[HPP_EV_ICR_WRITTEN] = 1'b1;
                    end
                    HPP_HA_MID: txw_next[15:8] = wdat_reg;
                    HPP_HA_FIRST: begin
                        if (little) txw_next[7:0] = wdat_reg;
                        else txw_next[23:16] = wdat_reg;
                    end
                    HPP_HA_LAST: begin
                        if (little) txw_next[23:16] = wdat_reg;
                        else txw_next[7:0] = wdat_reg;
                        ev_set[HPP_EV_TX_WRITTEN] = 1'b1;
                    end
                    default: ;
                endcase
            end
        end
        // Software side; a host last-byte write in the same cycle beats tx_take, but rx_load beats a host read
        if (tx_take && !(wr_rise && cur_addr == HPP_HA_LAST)) begin
            tx_full_next = 1'b0;
        end
        if (rx_load) begin
            rxw_next = i_avs_writedata[23:0];
            rx_full_next = 1'b1;
        end
        if (bus_take && i_avs_write && i_avs_address == HPP_OFF_VECTOR) begin
            vec_next = i_avs_writedata[7:0];
        end
        // Drive bus only during read or acknowledge
        doe_next = rd_act | ack_act;
        if (ack_act) begin
            dout_next = vec_reg;
        end else if (cur_addr == HPP_HA_ICR) begin
            dout_next = icr_reg;
        end else if (cur_addr == HPP_HA_STATUS) begin
            dout_next = {5'h00, settle_reg == 2'd0, tx_full_reg, rx_full_reg};
        end else if (cur_addr == HPP_HA_VECTOR) begin
            dout_next = vec_reg;
        end else begin
            dout_next = hpp_pick(rxw_reg, cur_addr, little);
        end
    end

    // Host side registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_d_reg <= 1'b0;
            wr_d_reg <= 1'b0;
            als_d_reg <= 1'b0;
            alat_reg <= 8'h00;
            acc_reg <= 3'h0;
            wdat_reg <= 8'h00;
            icr_reg <= HPP_ICR_RESET;
            settle_reg <= 2'd0;
            rxw_reg <= HPP_WORD_RESET;
            txw_reg <= HPP_WORD_RESET;
            rx_full_reg <= 1'b0;
            tx_full_reg <= 1'b0;
            vec_reg <= HPP_VECTOR_RESET;
            dout_reg <= 8'h00;
            doe_reg <= 1'b0;
        end else if (i_clk_en) begin
            rd_d_reg <= rd_d_next;
            wr_d_reg <= wr_d_next;
            als_d_reg <= als_d_next;
            alat_reg <= alat_next;
            acc_reg <= acc_next;
            wdat_reg <= wdat_next;
            icr_reg <= icr_next;
            settle_reg <= settle_next;
            rxw_reg <= rxw_next;
            txw_reg <= txw_next;
            rx_full_reg <= rx_full_next;
            tx_full_reg <= tx_full_next;
            vec_reg <= vec_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
        end
    end

    // Request levels; held off while a last-register strobe is active
    logic rx_req, tx_req, comb_req;
    always_comb begin
        rx_req = icr_reg[HPP_ICR_RX_REQ_EN] & rx_full_reg & ~last_rd;
        tx_req = icr_reg[HPP_ICR_TX_REQ_EN] & ~tx_full_reg & ~last_wr;
        comb_req = ~ctrl_reg[HPP_CTRL_DOUBLE_REQ] & (rx_req | tx_req);
    end
    hpp_req_drv u_hpp_req_drv [2:0] (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_assert({comb_req, ctrl_reg[HPP_CTRL_DOUBLE_REQ] & rx_req,
                   ctrl_reg[HPP_CTRL_DOUBLE_REQ] & tx_req}),
        .i_active_high(ctrl_reg[HPP_CTRL_REQ_POL]),
        .i_open_drain(ctrl_reg[HPP_CTRL_OPEN_DRAIN]),
        .o_pin_out({o_combined_host_request, o_receive_host_request,
                    o_transmit_host_request}),
        .o_pin_oe({o_combined_host_request_oe, o_receive_host_request_oe,
                   o_transmit_host_request_oe})
    );

    // Avalon slave: one wait cycle, answer on the second
    logic wait_reg, wait_next; // Waitrequest flop
    logic [31:0] rdata_reg, rdata_next; // Read data flop
    logic [2:0] irq_st_reg, irq_st_next; // Sticky events
    logic [2:0] irq_mask_reg, irq_mask_next; // Event enables
    logic irq_reg, irq_next; // Interrupt line
    always_comb begin
        bus_req = i_avs_read | i_avs_write;
        bus_take = bus_req & ~wait_reg;
        wait_next = ~(bus_req & wait_reg);
        rx_load = bus_take & i_avs_write & (i_avs_address == HPP_OFF_RX_DATA);
        tx_take = bus_take & i_avs_read & (i_avs_address == HPP_OFF_TX_DATA);
        ctrl_next = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        irq_st_next = irq_st_reg;
        rdata_next = rdata_reg;
        // Write one clears; a new event in the same cycle wins
        if (bus_take && i_avs_write) begin
            unique case (i_avs_address)
                HPP_OFF_CTRL: ctrl_next = i_avs_writedata[HPP_CTRL_W-1:0];
                HPP_OFF_IRQ_MASK: irq_mask_next = i_avs_writedata[HPP_EV_W-1:0];
                HPP_OFF_IRQ_STATUS: irq_st_next = irq_st_reg & ~i_avs_writedata[2:0];
                default: ;
            endcase
        end
        irq_st_next = irq_st_next | ev_set;
        irq_next = |(irq_st_next & irq_mask_next);
        if (bus_req && wait_reg && i_avs_read) begin
            unique case (i_avs_address)
                HPP_OFF_CTRL: rdata_next = {23'h00_0000, ctrl_reg};
                HPP_OFF_STATUS: rdata_next = {21'h00_0000, icr_reg,
                                              settle_reg == 2'd0, tx_full_reg, rx_full_reg};
                HPP_OFF_RX_DATA: rdata_next = {8'h00, rxw_reg};
                HPP_OFF_TX_DATA: rdata_next = {8'h00, txw_reg};
                HPP_OFF_IRQ_STATUS: rdata_next = {29'h0000_0000, irq_st_reg};
                HPP_OFF_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
                HPP_OFF_VECTOR: rdata_next = {24'h00_0000, vec_reg};
                default: rdata_next = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Avalon and interrupt registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= HPP_CTRL_RESET;
            irq_st_reg <= 3'b000;
            irq_mask_reg <= 3'b000;
            irq_reg <= 1'b0;
        end else if (i_clk_en) begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            irq_st_reg <= irq_st_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_irq = irq_reg;
    assign o_shared_addr_data_lines = dout_reg;
    assign o_shared_addr_data_lines_oe = doe_reg;
endmodule : hpp_host_port

// *** hpp_host_port_monitor.sv ***
// Port-level checker for the host parallel port
`timescale 1ns/100ps
module hpp_host_port_monitor (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Avalon side
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [4:0] i_avs_address,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_irq,
    // Host side
    input wire logic i_host_read_strobe,
    input wire logic i_host_write_strobe,
    input wire logic i_shared_data_strobe,
    input wire logic i_vector_acknowledge,
    input wire logic o_shared_addr_data_lines_oe,
    input wire logic o_combined_host_request,
    input wire logic o_receive_host_request
);
    // Inputs whose change may move an output
    wire [5:0] cause = {i_avs_read, i_avs_write, i_host_read_strobe, i_host_write_strobe,
        i_shared_data_strobe, i_vector_acknowledge};
    logic [5:0] cause_q; // Last cause levels
    logic [11:0] hist_reg; // Sync, commit and settle may take twelve edges
    // Change history, all ones after reset to excuse start-up
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cause_q <= 6'h00;
            hist_reg <= 12'hFFF;
        end else begin
            cause_q <= cause;
            hist_reg <= {hist_reg[10:0], cause != cause_q};
        end
    end
    wire recent = |hist_reg;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_asked; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
    sequence s_answered; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
    wait_answer_a: assert property (s_asked |=> s_answered) else $error("bad answer");
    idle_wait_a: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("answer without request");
    rdata_hold_a: assert property ($changed(o_avs_readdata) |-> $fell(o_avs_waitrequest))
        else $error("read data moved");
    write_keep_a: assert property ($fell(o_avs_waitrequest) && i_avs_write
        |-> $stable(o_avs_readdata)) else $error("write moved read data");
    unmapped_zero_a: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == 5'h1C
        |-> o_avs_readdata == 32'h0) else $error("hole not zero");
    oe_cause_a: assert property ($changed(o_shared_addr_data_lines_oe) |-> recent)
        else $error("bus drive without strobe");
    req_cause_a: assert property ($changed({o_combined_host_request, o_receive_host_request})
        |-> recent) else $error("request moved alone");
    irq_cause_a: assert property ($changed(o_irq) |-> recent) else $error("irq moved alone");
endmodule : hpp_host_port_monitor
bind hpp_host_port hpp_host_port_monitor u_hpp_host_port_monitor (.*);

// *** hpp_host_model.sv ***
// Behavioural host processor on the parallel pins
`timescale 1ns/100ps
module hpp_host_model (
    // Clock, mode and bus
    input wire logic i_sys_clk,
    input wire logic i_dual,
    input wire logic i_mux,
    input wire logic i_spol,
    input wire logic [7:0] i_bus,
    // Host pins
    output logic o_sel,
    output logic o_rd,
    output logic o_wr,
    output logic o_ds,
    output logic o_als,
    output logic o_dir,
    output logic [2:0] o_addr,
    output logic [7:0] o_data,
    output logic o_oe
);
    logic [4:0] act = 5'h00; // Active select, read, write, shared, latch
    // Strobe pin levels follow the programmed polarity; select and latch are active low
    assign o_sel = ~act[4];
    assign o_rd = act[3] ~^ i_spol;
    assign o_wr = act[2] ~^ i_spol;
    assign o_ds = act[1] ~^ i_spol;
    assign o_als = ~act[0];
    initial {o_dir, o_addr, o_data, o_oe} = 13'h1400; // Idle on a read-only index
    // One byte access; mux mode sends the index first
    task automatic xfer(input logic rd, input logic [2:0] idx, input logic [7:0] wd,
        output logic [7:0] q);
        @(posedge i_sys_clk);
        o_data <= i_mux ? {5'h00, idx} : wd;
        o_oe <= i_mux | !rd;
        act[0] <= i_mux;
        repeat (3) @(posedge i_sys_clk);
        act[0] <= 1'b0; // Index latched at this release
        repeat (3) @(posedge i_sys_clk);
        {o_dir, o_addr, o_data, o_oe} <= {rd, idx, wd, !rd};
        act[4] <= 1'b1;
        @(posedge i_sys_clk);
        act[3:1] <= i_dual ? {rd, !rd, 1'b0} : 3'h1;
        repeat (5) @(posedge i_sys_clk);
        q = i_bus;
        act[3:1] <= 3'h0;
        repeat (4) @(posedge i_sys_clk);
        act[4] <= 1'b0;
        o_oe <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
    endtask : xfer
endmodule : hpp_host_model

// *** tb_host_parallel_port_handshake.sv ***
// Self-checking bench for the host parallel port handshake block
`timescale 1ns/100ps
module tb_host_parallel_port_handshake import hpp_pkg::*; ;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, ack = 1'b1; // Bench drives
    logic dual = 1'b1, mux = 1'b0, spol = 1'b0; // Modes as programmed
    logic [4:0] addr = 5'h00;
    logic [31:0] wdat = 32'h0, rdq, got;
    logic wq, irq, doe, hoe, cr, cro, rr, sel, host_read_strobe, host_write_strobe, shared_data_strobe, als, dir;
    logic [2:0] ha;
    logic [7:0] dd, hd, last = 8'h00;
    // Released bus shows the inverse of its last level
    wire [7:0] bus = doe ? dd : hoe ? hd : ~last;
    int mismatches = 0, checks = 0;
    always @(posedge clk) last <= bus;
    initial forever #2 clk = ~clk;
    hpp_host_port u_hpp_host_port (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .o_avs_readdata(rdq), .o_avs_waitrequest(wq), .o_irq(irq), .i_port_select(sel),
        .i_host_read_strobe(host_read_strobe), .i_host_write_strobe(host_write_strobe), .i_shared_data_strobe(shared_data_strobe),
        .i_transfer_direction(dir), .i_address_latch_strobe(als), .i_vector_acknowledge(ack),
        .i_host_address_inputs(ha), .i_host_high_address(3'h0), .i_shared_addr_data_lines(bus),
        .o_shared_addr_data_lines(dd), .o_shared_addr_data_lines_oe(doe),
        .o_combined_host_request(cr), .o_combined_host_request_oe(cro),
        .o_receive_host_request(rr), .o_receive_host_request_oe(),
        .o_transmit_host_request(), .o_transmit_host_request_oe());
    hpp_host_model u_hpp_host_model (.i_sys_clk(clk), .i_dual(dual), .i_mux(mux), .i_spol(spol),
        .i_bus(bus), .o_sel(sel), .o_rd(host_read_strobe), .o_wr(host_write_strobe), .o_ds(shared_data_strobe), .o_als(als), .o_dir(dir),
        .o_addr(ha), .o_data(hd), .o_oe(hoe));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One Avalon cycle, held until waitrequest is seen low
    task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        {rd, wr, addr, wdat} <= {!w, w, a, d};
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        got = rdq;
        {rd, wr} <= 2'h0;
    endtask : avs
    task automatic hx(input logic r, input logic [2:0] i, input logic [7:0] d,
        output logic [7:0] q);
        u_hpp_host_model.xfer(r, i, d, q);
    endtask : hx
    task automatic wait8;
        repeat (8) @(posedge clk);
    endtask : wait8
    // Reset values, unmapped hole and the vector fetch
    task automatic t_regs;
        avs(0, HPP_OFF_CTRL, 32'h0);
        chk("ctrl", 32'(HPP_CTRL_RESET), got);
        avs(0, 5'h1C, 32'h0);
        chk("hole", 32'h0, got);
        @(posedge clk);
        ack <= 1'b0;
        repeat (5) @(posedge clk);
        chk("vector", 32'(HPP_VECTOR_RESET), 32'(bus));
        ack <= 1'b1;
        wait8;
        chk("released", 1'b0, doe);
    endtask : t_regs
    // Host writes a word in both byte orders; request and interrupt follow
    task automatic t_tx;
        logic [7:0] b;
        for (int o = 0; o < 2; o++) begin
            hx(0, HPP_HA_ICR, {o[0], 7'h02}, b);
            chk("tx req on", 1'b0, cr);
            hx(0, HPP_HA_FIRST, 8'hA1, b);
            hx(0, HPP_HA_MID, 8'hB2, b);
            hx(0, HPP_HA_LAST, 8'hC3, b);
            chk("tx req off", 1'b1, cr);
            chk("irq masked", 32'(o), irq);
            avs(0, HPP_OFF_TX_DATA, 32'h0);
            chk("tx word", o ? 32'h00C3_B2A1 : 32'h00A1_B2C3, got);
            avs(1, HPP_OFF_IRQ_MASK, 32'h1);
            avs(1, HPP_OFF_IRQ_STATUS, 32'h1);
            wait8;
            chk("tx req back", 1'b0, cr);
            chk("irq clear", 32'h0, irq);
        end
    endtask : t_tx
    // Mux bus, shared strobe, two request lines
    task automatic t_rx;
        logic [7:0] b0, b1, b2;
        avs(1, HPP_OFF_CTRL, 32'h6);
        {dual, mux} <= 2'h1;
        hx(0, HPP_HA_ICR, 8'h01, b0);
        chk("rx req idle", 1'b1, rr);
        avs(1, HPP_OFF_RX_DATA, 32'h0011_2233);
        wait8;
        chk("rx req on", 1'b0, rr);
        hx(1, HPP_HA_FIRST, 8'h00, b0);
        hx(1, HPP_HA_MID, 8'h00, b1);
        hx(1, HPP_HA_LAST, 8'h00, b2);
        chk("rx word", 32'h0011_2233, {8'h00, b0, b1, b2});
        chk("rx req off", 1'b1, rr);
        avs(1, HPP_OFF_CTRL, 32'h1);
        {dual, mux} <= 2'h2;
    endtask : t_rx
    // Active-high strobes with an open-drain request
    task automatic t_od;
        logic [7:0] b;
        avs(1, HPP_OFF_CTRL, 32'h19);
        spol <= 1'b1;
        wait8;
        chk("od idle", 1'b0, cro);
        avs(1, HPP_OFF_RX_DATA, 32'h0044_5566);
        wait8;
        chk("od on", 32'h1, {cr, cro});
        hx(1, HPP_HA_LAST, 8'h00, b);
        chk("od byte", 32'h66, b);
        chk("od off", 1'b0, cro);
    endtask : t_od
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_tx;
        t_rx;
        t_od;
        tally_and_finish;
    end
    // Watchdog, about ten times the expected run length
    initial begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
endmodule : tb_host_parallel_port_handshake
